// [logic/tcp_top.sv]
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`include "tcp_defines.svh"
// Overview of operation
// - code 123 enables all channels, synchronised
// - global off disables all; reset default
// - per-channel enable, default off, no waveform
// - per-channel first-phase level, default low
// - period 1 to 5000 us, default 1
// - first-phase percent 1 to 99, default 1
// - clamp percent to 1..99, never constant
// - shared delay staggers channel 2, then 3
// - single setting updates keep all others
// - outputs only, no capture of inputs
module tcp_top #(
	parameter int CYC = `TCP_CYC_PER_US,
	parameter int SUB_W = 6,
	parameter int PER_W = 13,
	parameter int PCT_W = 7,
	parameter int NCH = 3
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// register port
	input wire logic [`TCP_ADDR_W-1:0] addr,
	input wire logic [31:0] wdata,
	input wire logic we,
	input wire logic re,
	output logic [31:0] rdata,
	// pulse outputs
	output logic pulse_out_a,
	output logic pulse_out_b,
	output logic pulse_out_c
);
	import tcp_pkg::*;

	localparam int CW = PER_W + 1;

	logic [7:0] glob_q, glob_d;
	logic [NCH-1:0] on_q, on_d, pol_q, pol_d;
	logic [PER_W-1:0] per_q [NCH];
	logic [PER_W-1:0] per_d [NCH];
	logic [PCT_W-1:0] duty_q [NCH];
	logic [PCT_W-1:0] duty_d [NCH];
	logic [PER_W-1:0] delay_q, delay_d;
	logic [31:0] rdata_q, rdata_d;

	tcp_seq_e seq_q, seq_d;
	logic [CW-1:0] cnt_q, cnt_d;
	logic [PER_W-1:0] delay_sh_q, delay_sh_d;
	logic [NCH-1:0] done_q, done_d;
	logic any_q, all_q;

	logic tick;
	logic [SUB_W-1:0] sub;
	logic [NCH-1:0] en_eff, launch, run, lvl, pulse;
	logic any_en, mode_all, start;

	function automatic logic [PER_W-1:0] clamp_per(input logic [31:0] v);
		if (v < 32'(`TCP_PER_MIN)) begin
			return `TCP_PER_MIN;
		end else if (v > 32'(`TCP_PER_MAX)) begin
			return `TCP_PER_MAX;
		end
		return v[PER_W-1:0];
	endfunction

	function automatic logic [PCT_W-1:0] clamp_pct(input logic [31:0] v);
		if (v < 32'(`TCP_DUTY_MIN)) begin
			return `TCP_DUTY_MIN;
		end else if (v > 32'(`TCP_DUTY_MAX)) begin
			return `TCP_DUTY_MAX;
		end
		return v[PCT_W-1:0];
	endfunction

	function automatic logic [PER_W-1:0] clamp_delay(input logic [31:0] v);
		if (v > 32'(`TCP_DELAY_MAX)) begin
			return `TCP_DELAY_MAX;
		end
		return v[PER_W-1:0];
	endfunction

	// settings registers
	always_comb begin
		glob_d = glob_q;
		on_d = on_q;
		pol_d = pol_q;
		delay_d = delay_q;
		for (int i = 0; i < NCH; i++) begin
			per_d[i] = per_q[i];
			duty_d[i] = duty_q[i];
		end
		if (we) begin
			// each write touches one register only; a CHCTL write sets both the enables and the levels
			if (addr == `TCP_OFF_GLOBAL) begin
				glob_d = wdata[7:0];
			end
			if (addr == `TCP_OFF_CHCTL) begin
				on_d = wdata[`TCP_CHCTL_ON_LSB +: NCH];
				pol_d = wdata[`TCP_CHCTL_POL_LSB +: NCH];
			end
			if (addr == `TCP_OFF_DELAY) begin
				delay_d = clamp_delay(wdata);
			end
			for (int i = 0; i < NCH; i++) begin
				if (addr == `TCP_OFF_PER1 + 8'(i * 4)) begin
					per_d[i] = clamp_per(wdata);
				end
				if (addr == `TCP_OFF_PCT1 + 8'(i * 4)) begin
					duty_d[i] = clamp_pct(wdata);
				end
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			glob_q <= `TCP_GLOBAL_OFF;
			on_q <= '0;
			pol_q <= '0;
			delay_q <= `TCP_DELAY_RST;
			for (int i = 0; i < NCH; i++) begin
				per_q[i] <= `TCP_PER_RST;
				duty_q[i] <= `TCP_DUTY_RST;
			end
		end else begin
			glob_q <= glob_d;
			on_q <= on_d;
			pol_q <= pol_d;
			delay_q <= delay_d;
			for (int i = 0; i < NCH; i++) begin
				per_q[i] <= per_d[i];
				duty_q[i] <= duty_d[i];
			end
		end
	end

	// read port
	always_comb begin
		rdata_d = '0;
		if (re) begin
			case (addr)
				`TCP_OFF_GLOBAL: rdata_d = {24'h000000, glob_q};
				`TCP_OFF_CHCTL: begin
					rdata_d[`TCP_CHCTL_ON_LSB +: NCH] = on_q;
					rdata_d[`TCP_CHCTL_POL_LSB +: NCH] = pol_q;
				end
				`TCP_OFF_DELAY: rdata_d = 32'(delay_q);
				`TCP_OFF_STATUS: begin
					rdata_d[`TCP_STAT_RUN_LSB +: NCH] = run;
					rdata_d[`TCP_STAT_LVL_LSB +: NCH] = pulse;
					rdata_d[`TCP_STAT_SEQ_BIT] = (seq_q == TCP_SEQ_STAGGER);
				end
				default: begin
					for (int i = 0; i < NCH; i++) begin
						if (addr == `TCP_OFF_PER1 + 8'(i * 4)) begin
							rdata_d = 32'(per_q[i]);
						end
						if (addr == `TCP_OFF_PCT1 + 8'(i * 4)) begin
							rdata_d = 32'(duty_q[i]);
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign rdata = rdata_q;

	// channel enables
	always_comb begin
		mode_all = (glob_q == `TCP_GLOBAL_ALL);
		for (int i = 0; i < NCH; i++) begin
			en_eff[i] = mode_all || (glob_q == `TCP_GLOBAL_EACH && on_q[i]);
		end
		any_en = |en_eff;
		start = (any_en && !any_q) || (mode_all && !all_q);
	end

	// start sequencer with staggered launches
	always_comb begin
		seq_d = seq_q;
		cnt_d = cnt_q;
		delay_sh_d = delay_sh_q;
		done_d = done_q;
		launch = '0;
		case (seq_q)
			TCP_SEQ_IDLE: begin
				if (start) begin
					seq_d = TCP_SEQ_STAGGER;
					cnt_d = '0;
					delay_sh_d = delay_q;
					done_d = '0;
				end else begin
					// late individual enable joins at the next tick
					launch = tick ? (en_eff & ~run) : '0;
				end
			end
			TCP_SEQ_STAGGER: begin
				if (!any_en) begin
					seq_d = TCP_SEQ_IDLE;
				end else if (tick) begin
					for (int i = 0; i < NCH; i++) begin
						if (!done_q[i] && cnt_q == CW'(i) * CW'(delay_sh_q)) begin
							launch[i] = en_eff[i];
							done_d[i] = 1'b1;
						end
					end
					cnt_d = cnt_q + CW'(1);
					if (&done_d) begin
						seq_d = TCP_SEQ_IDLE;
					end
				end
			end
			default: seq_d = TCP_SEQ_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			seq_q <= TCP_SEQ_IDLE;
			cnt_q <= '0;
			delay_sh_q <= `TCP_DELAY_RST;
			done_q <= '0;
			any_q <= 1'b0;
			all_q <= 1'b0;
		end else begin
			seq_q <= seq_d;
			cnt_q <= cnt_d;
			delay_sh_q <= delay_sh_d;
			done_q <= done_d;
			any_q <= any_en;
			all_q <= mode_all;
		end
	end

	tcp_tick_gen #(
		.CYC(CYC),
		.SUB_W(SUB_W)
	) u_tick (
		.clk(clk),
		.rst(rst),
		.tick(tick),
		.sub(sub)
	);

	generate
		for (genvar g = 0; g < NCH; g++) begin : g_ch
			tcp_channel #(
				.CYC(CYC),
				.SUB_W(SUB_W),
				.PER_W(PER_W),
				.PCT_W(PCT_W)
			) u_ch (
				.clk(clk),
				.rst(rst),
				.tick(tick),
				.sub(sub),
				.en(en_eff[g]),
				.launch(launch[g]),
				.period(per_q[g]),
				.duty(duty_q[g]),
				.pol(pol_q[g]),
				.running(run[g]),
				.level(lvl[g]),
				.pulse(pulse[g])
			);
		end
	endgenerate

	// outputs only: nothing here samples the pins
	assign pulse_out_a = pulse[0];
	assign pulse_out_b = pulse[1];
	assign pulse_out_c = pulse[2];

	property p_duty_hi;
		@(posedge clk) disable iff (rst) we && addr == `TCP_OFF_PCT1 && wdata > 32'h0000_0063 |=> duty_q[0] == `TCP_DUTY_MAX;
	endproperty
	a_duty_hi: assert property (p_duty_hi) else $error("duty not clamped to 99");

	property p_duty_lo;
		@(posedge clk) disable iff (rst) we && addr == `TCP_OFF_PCT1 && wdata == 32'h0000_0000 |=> duty_q[0] == `TCP_DUTY_MIN;
	endproperty
	a_duty_lo: assert property (p_duty_lo) else $error("duty not clamped to 1");

	property p_all_on;
		@(posedge clk) disable iff (rst) glob_q == `TCP_GLOBAL_ALL
			|-> en_eff == 3'h7 && (all_q || seq_q == TCP_SEQ_STAGGER || seq_d == TCP_SEQ_STAGGER);
	endproperty
	a_all_on: assert property (p_all_on) else $error("all-channel code did not enable");

	sequence s_off3;
		(glob_q == `TCP_GLOBAL_OFF) [*3];
	endsequence
	property p_global_off;
		@(posedge clk) disable iff (rst) s_off3 |-> !pulse_out_a && !pulse_out_b && !pulse_out_c;
	endproperty
	a_global_off: assert property (p_global_off) else $error("output active while off");

	property p_keep_others;
		@(posedge clk) disable iff (rst) we && addr == `TCP_OFF_PER1
			|=> $stable(per_q[1]) && $stable(per_q[2]) && $stable(delay_q) && $stable(duty_q[0]);
	endproperty
	a_keep_others: assert property (p_keep_others) else $error("other setting disturbed");

	property p_stagger;
		@(posedge clk) disable iff (rst) seq_q == TCP_SEQ_STAGGER && launch[2] && done_q[0]
			|-> cnt_q == 14'(2) * {1'b0, delay_sh_q};
	endproperty
	a_stagger: assert property (p_stagger) else $error("channel 3 launched off its offset");

	c_all_on: cover property (@(posedge clk) disable iff (rst) $rose(mode_all) ##[1:200] &run);
	c_stagger: cover property (@(posedge clk) disable iff (rst) seq_q == TCP_SEQ_STAGGER && delay_sh_q != '0 && launch[2]);
	c_duty_clamp: cover property (@(posedge clk) disable iff (rst) we && addr == `TCP_OFF_PCT1 && wdata > 32'h0000_0063);
endmodule

// [logic/tcp_defines.svh]
`ifndef TCP_DEFINES_SVH
`define TCP_DEFINES_SVH

// timing
`define TCP_CLK_PERIOD_NS 25
`define TCP_TICK_NS 1000
`define TCP_CYC_PER_US (`TCP_TICK_NS / `TCP_CLK_PERIOD_NS)

// register port
`define TCP_ADDR_W 8
`define TCP_OFF_GLOBAL 8'h00
`define TCP_OFF_CHCTL 8'h04
`define TCP_OFF_PER1 8'h08
`define TCP_OFF_PCT1 8'h14
`define TCP_OFF_DELAY 8'h20
`define TCP_OFF_STATUS 8'h24
`define TCP_OFF_STRIDE 8'h04

// fields
`define TCP_CHCTL_ON_LSB 0
`define TCP_CHCTL_POL_LSB 4
`define TCP_STAT_RUN_LSB 0
`define TCP_STAT_LVL_LSB 4
`define TCP_STAT_SEQ_BIT 8

// global mode codes
`define TCP_GLOBAL_OFF 8'h00
`define TCP_GLOBAL_EACH 8'h01
`define TCP_GLOBAL_ALL 8'h7B

// reset values and limits
`define TCP_PER_RST 13'h0001
`define TCP_PER_MIN 13'h0001
`define TCP_PER_MAX 13'h1388
`define TCP_DUTY_RST 7'h01
`define TCP_DUTY_MIN 7'h01
`define TCP_DUTY_MAX 7'h63
`define TCP_DELAY_RST 13'h0000
`define TCP_DELAY_MAX 13'h1388

`endif

// [logic/tcp_pkg.sv]
package tcp_pkg;
	typedef enum logic [1:0] {
		TCP_SEQ_IDLE = 2'b01,
		TCP_SEQ_STAGGER = 2'b10
	} tcp_seq_e;
	typedef logic [12:0] tcp_us_t;
	typedef logic [6:0] tcp_pct_t;
endpackage

// [logic/tcp_tick_gen.sv]
`timescale 1ns/10ps
`include "tcp_defines.svh"
module tcp_tick_gen #(
	parameter int CYC = `TCP_CYC_PER_US,
	parameter int SUB_W = 6
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// common time base
	output logic tick,
	output logic [SUB_W-1:0] sub
);
	import tcp_pkg::*;

	logic [SUB_W-1:0] sub_q, sub_d;

	assign tick = (sub_q == SUB_W'(CYC - 1));
	assign sub = sub_q;

	always_comb begin
		sub_d = tick ? '0 : sub_q + SUB_W'(1);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sub_q <= '0;
		end else begin
			sub_q <= sub_d;
		end
	end
endmodule

// [logic/tcp_channel.sv]
`timescale 1ns/10ps
`include "tcp_defines.svh"
module tcp_channel #(
	parameter int CYC = `TCP_CYC_PER_US,
	parameter int SUB_W = 6,
	parameter int PER_W = 13,
	parameter int PCT_W = 7
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// time base
	input wire logic tick,
	input wire logic [SUB_W-1:0] sub,
	// settings
	input wire logic en,
	input wire logic launch,
	input wire logic [PER_W-1:0] period,
	input wire logic [PCT_W-1:0] duty,
	input wire logic pol,
	// state and output
	output logic running,
	output logic level,
	output logic pulse
);
	import tcp_pkg::*;

	localparam int THR_W = 25;

	logic run_q, run_d, pol_sh_q, pol_sh_d, out_q, out_d;
	logic [PER_W-1:0] us_q, us_d, per_sh_q, per_sh_d;
	logic [THR_W-1:0] thr_sh_q, thr_sh_d, pos;
	logic last_us, last_cyc, load, first;

	always_comb begin
		last_us = (us_q == per_sh_q - PER_W'(1));
		last_cyc = last_us && (sub == SUB_W'(CYC - 1));
		pos = THR_W'(us_q) * THR_W'(CYC) + THR_W'(sub);
		// last clock of the period always shows the second phase
		first = (pos * THR_W'(100) < thr_sh_q) && !last_cyc;
		level = first ? pol_sh_q : !pol_sh_q;
		load = (launch && tick) || (run_q && tick && last_us);
		run_d = en ? (run_q || (launch && tick)) : 1'b0;
		us_d = us_q;
		if (load) begin
			us_d = '0;
		end else if (run_q && tick) begin
			us_d = us_q + PER_W'(1);
		end
		per_sh_d = load ? period : per_sh_q;
		pol_sh_d = load ? pol : pol_sh_q;
		thr_sh_d = load ? THR_W'(period) * THR_W'(CYC) * THR_W'(duty) : thr_sh_q;
		out_d = run_q && en && level;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			run_q <= 1'b0;
			us_q <= '0;
			per_sh_q <= `TCP_PER_RST;
			thr_sh_q <= '0;
			pol_sh_q <= 1'b0;
			out_q <= 1'b0;
		end else begin
			run_q <= run_d;
			us_q <= us_d;
			per_sh_q <= per_sh_d;
			thr_sh_q <= thr_sh_d;
			pol_sh_q <= pol_sh_d;
			out_q <= out_d;
		end
	end

	assign running = run_q;
	assign pulse = out_q;

	property p_first_phase;
		@(posedge clk) disable iff (rst) $rose(run_q) && en |=> pulse == $past(pol_sh_q);
	endproperty
	a_first_phase: assert property (p_first_phase) else $error("first phase level wrong");

	property p_shadow_hold;
		@(posedge clk) disable iff (rst) run_q && !load |=> $stable(thr_sh_q) && $stable(pol_sh_q);
	endproperty
	a_shadow_hold: assert property (p_shadow_hold) else $error("setting applied mid period");

	property p_last_opposite;
		@(posedge clk) disable iff (rst) run_q && en && last_cyc |=> pulse == !$past(pol_sh_q);
	endproperty
	a_last_opposite: assert property (p_last_opposite) else $error("output held at one level");

	property p_off_quiet;
		@(posedge clk) disable iff (rst) !en |=> !run_q ##1 !pulse;
	endproperty
	a_off_quiet: assert property (p_off_quiet) else $error("disabled channel still drives");
endmodule

// [sim/tcp_load.sv]
`timescale 1ns/10ps
// behavioural load on one pulse pin: counts high cycles and stamps the first rise
module tcp_load (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// load pin and measurement restart
	input wire logic drive,
	input wire logic clr,
	// measured values
	output logic [15:0] hi_cnt,
	output logic [15:0] rise_at
);
	logic [15:0] age_q;
	logic last_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			age_q <= 16'h0000;
			hi_cnt <= 16'h0000;
			rise_at <= 16'hFFFF;
			last_q <= 1'b0;
		end else if (clr) begin
			age_q <= 16'h0000;
			hi_cnt <= 16'h0000;
			rise_at <= 16'hFFFF;
			last_q <= drive;
		end else begin
			age_q <= age_q + 16'h0001;
			hi_cnt <= hi_cnt + {15'h0000, drive};
			last_q <= drive;
			if (drive && !last_q && rise_at == 16'hFFFF) begin
				rise_at <= age_q;
			end
		end
	end
endmodule

// [sim/tb.sv]
`timescale 1ns/10ps
`include "tcp_defines.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
	$display("Error %s expected %0h seen %0h", nm, e, g); end end
module tb;
	import tcp_pkg::*;
	localparam int CYC = 4;
	typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e;} tcp_row_s;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic we = 1'b0;
	logic re = 1'b0;
	logic clr = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic [31:0] rdata;
	wire [2:0] pout;
	wire [15:0] hi [3];
	wire [15:0] rise [3];
	int n_errors = 0;
	int n_checks = 0;
	int dl [2] = '{0, 3};
	tcp_row_s rows [9] = '{
		'{8'h08, 32'd0, 32'd1},
		'{8'h08, 32'd6000, 32'd5000},
		'{8'h0C, 32'd2, 32'd2},
		'{8'h14, 32'd0, 32'd1},
		'{8'h14, 32'd100, 32'd99},
		'{8'h18, 32'd25, 32'd25},
		'{8'h20, 32'd6000, 32'd5000},
		'{8'h20, 32'd0, 32'd0},
		'{8'h30, 32'd5, 32'd0}
	};

	always #12.5 clk = ~clk;

	tcp_top #(.CYC(CYC), .SUB_W(2)) dut (
		.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .we(we), .re(re), .rdata(rdata),
		.pulse_out_a(pout[0]), .pulse_out_b(pout[1]), .pulse_out_c(pout[2])
	);
	for (genvar i = 0; i < 3; i++) begin : g_ld
		tcp_load ld (.clk(clk), .rst(rst), .drive(pout[i]), .clr(clr), .hi_cnt(hi[i]), .rise_at(rise[i]));
	end

	task automatic complete_run();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		we <= 1'b1;
		@(posedge clk);
		we <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		re <= 1'b1;
		@(posedge clk);
		re <= 1'b0;
		#1;
		`CHK("rdata", e, rdata)
		@(posedge clk);
		#1;
		`CHK("rdata_idle", 32'h0000_0000, rdata)
	endtask

	task automatic restart_meas();
		@(posedge clk);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
	endtask

	// high cycles of each pin over a whole number of periods
	task automatic measure(input int win, input logic [15:0] e0, input logic [15:0] e1, input logic [15:0] e2);
		repeat (40) @(posedge clk);
		restart_meas();
		repeat (win) @(posedge clk);
		#1;
		`CHK("hi_a", e0, hi[0])
		`CHK("hi_b", e1, hi[1])
		`CHK("hi_c", e2, hi[2])
	endtask

	initial begin
		#(25 * 6000);
		n_errors++;
		complete_run();
	end

	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		#1;
		`CHK("pout_rst", 3'b000, pout)
		for (int i = 0; i < 10; i++) begin
			rd_chk(8'(i * 4), (i >= 2 && i <= 7) ? 32'd1 : 32'd0);
		end
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].w);
			rd_chk(rows[i].a, rows[i].e);
		end
		wr(`TCP_OFF_GLOBAL, 32'h01);
		wr(`TCP_OFF_CHCTL, 32'h70);
		measure(80, 16'd0, 16'd0, 16'd0);
		wr(`TCP_OFF_PER1, 32'd1);
		wr(`TCP_OFF_CHCTL, 32'h37);
		measure(80, 16'd60, 16'd20, 16'd60);
		wr(`TCP_OFF_PCT1 + 8'h04, 32'd50);
		measure(80, 16'd60, 16'd40, 16'd60);
		rd_chk(`TCP_OFF_PER1 + 8'h04, 32'd2);
		wr(`TCP_OFF_PER1 + 8'h04, 32'd1);
		wr(`TCP_OFF_CHCTL, 32'h77);
		foreach (dl[k]) begin
			wr(`TCP_OFF_GLOBAL, 32'h00);
			measure(40, 16'd0, 16'd0, 16'd0);
			wr(`TCP_OFF_DELAY, 32'(dl[k]));
			restart_meas();
			wr(`TCP_OFF_GLOBAL, 32'h7B);
			repeat (80) @(posedge clk);
			#1;
			`CHK("first_rise_a", 1'b1, rise[0] < 16'd20)
			`CHK("offset_b", 16'(dl[k] * CYC), 16'(rise[1] - rise[0]))
			`CHK("offset_c", 16'(dl[k] * CYC), 16'(rise[2] - rise[1]))
		end
		// an unknown global code leaves every channel off
		wr(`TCP_OFF_GLOBAL, 32'h05);
		measure(40, 16'd0, 16'd0, 16'd0);
		// reset in mid-run while channels 1 and 2 are running and channel 3 has not yet launched
		wr(`TCP_OFF_GLOBAL, 32'h7B);
		repeat (20) @(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1;
		`CHK("pout_mid_rst", 3'b000, pout)
		rd_chk(`TCP_OFF_GLOBAL, 32'h0000_0000);
		rd_chk(`TCP_OFF_CHCTL, 32'h0000_0000);
		rd_chk(`TCP_OFF_PER1, 32'h0000_0001);
		rd_chk(`TCP_OFF_PCT1, 32'h0000_0001);
		rd_chk(`TCP_OFF_DELAY, 32'h0000_0000);
		measure(40, 16'd0, 16'd0, 16'd0);
		complete_run();
	end
endmodule
